// ===== rtl/cmb_board.sv
// Core memory board cycle logic: address latch, board select, drive, word buffer.
// Assumes the processor sequences all strobes; pins are asynchronous to clk.
`timescale 1ns/10ps
module cmb_board #(
	parameter int BOARD_WORDS = cmb_pkg::SIZE_1K,
	parameter int CODE_W      = cmb_pkg::CODE_W_1K,
	parameter int LOW_W       = cmb_pkg::ADDR_W - cmb_pkg::CODE_MSB - CODE_W
) (
	input  wire logic                       clk,
	input  wire logic                       rst_b,
	input  wire logic [CODE_W-1:0]          board_code,
	input  wire logic                       address_latch_pulse,
	input  wire logic                       read_1,
	input  wire logic                       read_2,
	input  wire logic                       sense_strobe,
	input  wire logic                       buf_load,
	input  wire logic                       buf_clear,
	input  wire logic                       inhibit,
	input  wire logic                       drive_io,
	input  wire logic                       read_io,
	input  wire logic                       sel_block,
	input  wire logic                       reload_dis,
	input  wire logic                       inh_tran,
	input  wire logic [cmb_pkg::WORD_W-1:0] sense_in,
	input  wire logic [cmb_pkg::WORD_W-1:0] cpu_to_memory_bus,
	input  wire logic [cmb_pkg::WORD_W-1:0] io_data_in,
	output logic      [cmb_pkg::WORD_W-1:0] io_data_out,
	output logic                            io_data_oe,
	output logic      [cmb_pkg::WORD_W-1:0] mem_to_cpu_bus,
	output logic                            selected,
	output logic      [LOW_W-1:0]           word_select,
	output logic                            read_drive,
	output logic                            write_drive,
	output logic      [cmb_pkg::WORD_W-1:0] inhibit_drive
);
	cmb_strobe_if sb ();
	logic [cmb_pkg::WORD_W-1:0] mbo1_reg, mbo2_reg;
	logic [cmb_pkg::WORD_W-1:0] io1_reg, io2_reg;
	logic [cmb_pkg::ADDR_W-1:0] word_address_register_reg, word_address_register_next;
	logic [cmb_pkg::WORD_W-1:0] word_buffer_reg, word_buffer_next;
	cmb_pkg::cmb_phase_e        phase_reg, phase_next;
	logic                       match;
	logic                       inh_tran_s1_reg, inh_tran_s2_reg;

	cmb_sync u_sync (
		.clk                 (clk),
		.rst_b               (rst_b),
		.address_latch_pulse (address_latch_pulse),
		.read_1              (read_1),
		.read_2              (read_2),
		.sense_strobe        (sense_strobe),
		.buf_load            (buf_load),
		.buf_clear           (buf_clear),
		.inhibit             (inhibit),
		.drive_io            (drive_io),
		.read_io             (read_io),
		.sel_block           (sel_block),
		.reload_dis          (reload_dis),
		.sense_in            (sense_in),
		.sb                  (sb)
	);

	// Data buses synchronised alongside the strobes
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			mbo1_reg        <= cmb_pkg::WORD_ZERO;
			mbo2_reg        <= cmb_pkg::WORD_ZERO;
			io1_reg         <= cmb_pkg::WORD_ZERO;
			io2_reg         <= cmb_pkg::WORD_ZERO;
			inh_tran_s1_reg <= 1'b0;
			inh_tran_s2_reg <= 1'b0;
		end else begin
			mbo1_reg        <= cpu_to_memory_bus;
			mbo2_reg        <= mbo1_reg;
			io1_reg         <= io_data_in;
			io2_reg         <= io1_reg;
			inh_tran_s1_reg <= inh_tran;
			inh_tran_s2_reg <= inh_tran_s1_reg;
		end
	end

	// Board code sits just below the unused top address bit
	assign match = (word_address_register_reg[cmb_pkg::ADDR_W-1-cmb_pkg::CODE_MSB -: CODE_W]
		== board_code) && !sb.sel_block;
	assign word_select = word_address_register_reg[LOW_W-1:0];

	always_comb begin
		word_address_register_next = word_address_register_reg;
		word_buffer_next           = word_buffer_reg;
		phase_next                 = phase_reg;
		// All boards latch the broadcast address together
		if (sb.addr_load) begin
			word_address_register_next = sb.read_io ? mbo2_reg : io2_reg;
		end
		if (sb.buf_clear && match) begin
			word_buffer_next = cmb_pkg::WORD_ZERO;
		end
		if (sb.sense_strobe && match && phase_reg == cmb_pkg::CMB_READ) begin
			word_buffer_next = word_buffer_reg | sb.sense;
		end
		if (sb.buf_load && match && !sb.reload_dis && phase_reg != cmb_pkg::CMB_WRITE) begin
			word_buffer_next = sb.read_io ? mbo2_reg : io2_reg;
		end
		unique case (phase_reg)
			cmb_pkg::CMB_IDLE: begin
				if (sb.read_sel && match) begin
					phase_next = cmb_pkg::CMB_READ;
				end
			end
			cmb_pkg::CMB_READ: begin
				if (!sb.read_sel) begin
					phase_next = cmb_pkg::CMB_WRITE;
				end
			end
			cmb_pkg::CMB_WRITE: begin
				if (sb.read_sel || !sb.inhibit) begin
					phase_next = cmb_pkg::CMB_IDLE;
				end
			end
		endcase
		if (sb.addr_load) begin
			phase_next = cmb_pkg::CMB_IDLE;
		end
	end

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			word_address_register_reg <= '0;
			word_buffer_reg           <= cmb_pkg::WORD_ZERO;
			phase_reg                 <= cmb_pkg::CMB_IDLE;
		end else begin
			word_address_register_reg <= word_address_register_next;
			word_buffer_reg           <= word_buffer_next;
			phase_reg                 <= phase_next;
		end
	end

	assign selected      = match;
	assign read_drive    = (phase_reg == cmb_pkg::CMB_READ) && sb.read_sel && match;
	// Drive stops with inhibit, or the zero bits would be written as ones
	assign write_drive   = (phase_reg == cmb_pkg::CMB_WRITE) && sb.inhibit && match;
	// Inhibit only the zero bits so the buffer is rewritten
	assign inhibit_drive = (write_drive && sb.inhibit) ? ~word_buffer_reg
		: cmb_pkg::WORD_ZERO;
	assign mem_to_cpu_bus = (match && !inh_tran_s2_reg) ? word_buffer_reg
		: cmb_pkg::WORD_ZERO;
	assign io_data_out   = word_buffer_reg;
	assign io_data_oe    = sb.drive_io && match;

	// Word buffer capture, load and hold
	AST_NO_SENSE_IN_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
		(phase_reg == cmb_pkg::CMB_WRITE && !sb.buf_load && !sb.buf_clear && !sb.addr_load)
		|=> word_buffer_reg == $past(word_buffer_reg))
		else $error("buffer changed during write");
	AST_SENSE_ONLY_READ: assert property (@(posedge clk) disable iff (!rst_b)
		(sb.sense_strobe && phase_reg != cmb_pkg::CMB_READ && !sb.buf_load && !sb.buf_clear)
		|=> word_buffer_reg == $past(word_buffer_reg))
		else $error("sense captured outside read");
	AST_SENSE_SETS: assert property (@(posedge clk) disable iff (!rst_b)
		(sb.sense_strobe && match && phase_reg == cmb_pkg::CMB_READ && !sb.buf_load)
		|=> (word_buffer_reg & $past(sb.sense)) == $past(sb.sense))
		else $error("sense not captured");
	AST_BITS_HOLD: assert property (@(posedge clk) disable iff (!rst_b)
		(sb.sense_strobe && !sb.buf_load && !sb.buf_clear)
		|=> (word_buffer_reg & $past(word_buffer_reg)) == $past(word_buffer_reg))
		else $error("buffer bit lost");
	AST_CLEAR_WORD: assert property (@(posedge clk) disable iff (!rst_b)
		(sb.buf_clear && match && !sb.sense_strobe && !sb.buf_load)
		|=> word_buffer_reg == cmb_pkg::WORD_ZERO)
		else $error("buffer not cleared");
	AST_LOAD_WORD: assert property (@(posedge clk) disable iff (!rst_b)
		(sb.buf_load && match && !sb.reload_dis && phase_reg == cmb_pkg::CMB_READ && sb.read_io)
		|=> word_buffer_reg == $past(mbo2_reg))
		else $error("new word not loaded");
	AST_RELOAD_DIS: assert property (@(posedge clk) disable iff (!rst_b)
		(sb.reload_dis && sb.buf_load && !sb.sense_strobe && !sb.buf_clear)
		|=> word_buffer_reg == $past(word_buffer_reg))
		else $error("load not suppressed");

	// Address latch and board select
	AST_ADDR_LATCH: assert property (@(posedge clk) disable iff (!rst_b)
		(sb.addr_load && sb.read_io)
		|=> word_address_register_reg == $past(mbo2_reg))
		else $error("address not latched");
	AST_ADDR_IO_PATH: assert property (@(posedge clk) disable iff (!rst_b)
		(sb.addr_load && !sb.read_io)
		|=> word_address_register_reg == $past(io2_reg))
		else $error("address not latched from I/O bus");
	AST_MATCH_CODE: assert property (@(posedge clk) disable iff (!rst_b)
		selected |->
		word_address_register_reg[cmb_pkg::ADDR_W-1-cmb_pkg::CODE_MSB -: CODE_W] == board_code)
		else $error("selected on foreign code");
	AST_BLOCK_SEL: assert property (@(posedge clk) disable iff (!rst_b)
		sb.sel_block |-> !selected && !read_drive && !io_data_oe)
		else $error("selected while blocked");
	AST_WORD_IN_BOARD: assert property (@(posedge clk) disable iff (!rst_b)
		selected |-> int'(word_select) < BOARD_WORDS)
		else $error("word outside board");

	// Cycle sequencing and drive
	AST_READ_THEN_WRITE: assert property (@(posedge clk) disable iff (!rst_b)
		(phase_reg == cmb_pkg::CMB_READ && !sb.read_sel && !sb.addr_load)
		|=> phase_reg == cmb_pkg::CMB_WRITE)
		else $error("read not followed by write");
	AST_IDLE_ON_LOAD: assert property (@(posedge clk) disable iff (!rst_b)
		sb.addr_load |=> phase_reg == cmb_pkg::CMB_IDLE)
		else $error("phase not restarted by new address");
	AST_READ_ONLY_SELECTED: assert property (@(posedge clk) disable iff (!rst_b)
		read_drive |-> selected && sb.read_sel && !write_drive)
		else $error("read drive on unselected board");
	AST_WRITE_TIMED: assert property (@(posedge clk) disable iff (!rst_b)
		write_drive |-> sb.inhibit && selected && phase_reg == cmb_pkg::CMB_WRITE)
		else $error("write drive outside inhibit time");
	AST_INHIBIT_ZEROS: assert property (@(posedge clk) disable iff (!rst_b)
		(write_drive && sb.inhibit) |-> (inhibit_drive & word_buffer_reg) == '0
		&& (inhibit_drive | word_buffer_reg) == '1)
		else $error("inhibit pattern wrong");

	// Output buses
	AST_BUS_QUIET: assert property (@(posedge clk) disable iff (!rst_b)
		!selected |-> mem_to_cpu_bus == cmb_pkg::WORD_ZERO && !io_data_oe)
		else $error("unselected board drives a bus");
	AST_IO_DRIVE: assert property (@(posedge clk) disable iff (!rst_b)
		(sb.drive_io && match) |-> io_data_oe && io_data_out == word_buffer_reg)
		else $error("buffer not driven to I/O bus");
endmodule : cmb_board

// ===== rtl/cmb_pkg.sv
// Constants and types for the core memory board cycle logic.
// Assumes one 40 MHz clock and processor strobes synchronised inside the board.
package cmb_pkg;
	localparam int WORD_W    = 16;
	localparam int ADDR_W    = 16;
	localparam int CODE_MSB  = 1;
	localparam int SIZE_1K   = 1024;
	localparam int SIZE_2K   = 2048;
	localparam int SIZE_4K   = 4096;
	localparam int SIZE_8K   = 8192;
	localparam int CODE_W_1K = 5;
	localparam int CODE_W_2K = 4;
	localparam int CODE_W_4K = 3;
	localparam int CODE_W_8K = 2;
	localparam logic [WORD_W-1:0] WORD_ZERO = 16'h0000;
	typedef enum logic [1:0] {
		CMB_IDLE,
		CMB_READ,
		CMB_WRITE
	} cmb_phase_e;
endpackage : cmb_pkg

// ===== rtl/cmb_strobe_if.sv
// Synchronised processor strobes passed from the pin stage to the cycle logic.
// Assumes both ends share clk.
`timescale 1ns/10ps
interface cmb_strobe_if;
	logic                            addr_load;
	logic                            read_sel;
	logic                            sense_strobe;
	logic                            buf_load;
	logic                            buf_clear;
	logic                            inhibit;
	logic                            drive_io;
	logic                            read_io;
	logic                            sel_block;
	logic                            reload_dis;
	logic [cmb_pkg::WORD_W-1:0]      sense;
	modport src (output addr_load, read_sel, sense_strobe, buf_load, buf_clear, inhibit,
		drive_io, read_io, sel_block, reload_dis, sense);
	modport dst (input addr_load, read_sel, sense_strobe, buf_load, buf_clear, inhibit,
		drive_io, read_io, sel_block, reload_dis, sense);
endinterface : cmb_strobe_if

// ===== rtl/cmb_sync.sv
// Two-flop synchronisers for the processor strobe pins and the sense amplifiers.
// Assumes the pins are asynchronous to clk; rising edges of the address latch, sense, load and clear pins become one-cycle pulses.
`timescale 1ns/10ps
module cmb_sync (
	input  wire logic                       clk,
	input  wire logic                       rst_b,
	input  wire logic                       address_latch_pulse,
	input  wire logic                       read_1,
	input  wire logic                       read_2,
	input  wire logic                       sense_strobe,
	input  wire logic                       buf_load,
	input  wire logic                       buf_clear,
	input  wire logic                       inhibit,
	input  wire logic                       drive_io,
	input  wire logic                       read_io,
	input  wire logic                       sel_block,
	input  wire logic                       reload_dis,
	input  wire logic [cmb_pkg::WORD_W-1:0] sense_in,
	cmb_strobe_if.src                       sb
);
	localparam int N = 11 + cmb_pkg::WORD_W;
	logic [N-1:0] s1_reg, s2_reg, s3_reg;
	logic [N-1:0] s1_next, s2_next, s3_next;
	logic [N-1:0] pins;
	assign pins = {sense_in, reload_dis, sel_block, read_io, drive_io, inhibit, buf_clear,
		buf_load, sense_strobe, read_2, read_1, address_latch_pulse};
	always_comb begin
		s1_next = pins;
		s2_next = s1_reg;
		s3_next = s2_reg;
	end
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			s1_reg <= '0;
			s2_reg <= '0;
			s3_reg <= '0;
		end else begin
			s1_reg <= s1_next;
			s2_reg <= s2_next;
			s3_reg <= s3_next;
		end
	end
	// Edge pulses from second and third stages only
	assign sb.addr_load    = s2_reg[0] & ~s3_reg[0];
	assign sb.read_sel     = s2_reg[1] & s2_reg[2];
	assign sb.sense_strobe = s2_reg[3] & ~s3_reg[3];
	assign sb.buf_load     = s2_reg[4] & ~s3_reg[4];
	assign sb.buf_clear    = s2_reg[5] & ~s3_reg[5];
	assign sb.inhibit      = s2_reg[6];
	assign sb.drive_io     = s2_reg[7];
	assign sb.read_io      = s2_reg[8];
	assign sb.sel_block    = s2_reg[9];
	assign sb.reload_dis   = s2_reg[10];
	assign sb.sense        = s2_reg[N-1:11];
endmodule : cmb_sync

// ===== bench/cmb_cpu_model.sv
// Processor model: sequences the board strobes and stands in for the core plane.
// Assumes one board and pins changed only at the falling clock edge.
`timescale 1ns/10ps
module cmb_cpu_model #(
	parameter int LOW_W = 10
) (
	input  wire logic             clk,
	input  wire logic             read_drive,
	input  wire logic             write_drive,
	input  wire logic             selected,
	input  wire logic [LOW_W-1:0] word_select,
	input  wire logic [15:0]      inhibit_drive,
	input  wire logic [15:0]      mem_to_cpu_bus,
	output logic                  address_latch_pulse,
	output logic                  read_1,
	output logic                  read_2,
	output logic                  sense_strobe,
	output logic                  buf_load,
	output logic                  buf_clear,
	output logic                  inhibit,
	output logic                  read_io,
	output logic [15:0]           sense_in,
	output logic [15:0]           cpu_to_memory_bus,
	output logic [15:0]           io_data_in
);
	logic [15:0] core [2**LOW_W];
	logic [15:0] rd_word;
	logic        rd_prev;

	initial begin
		foreach (core[i]) core[i] = 16'h0000;
		{address_latch_pulse, read_1, read_2, sense_strobe} = 4'h0;
		{buf_load, buf_clear, inhibit, rd_prev} = 4'h0;
		read_io = 1'b1;
		sense_in = 16'h0000;
		cpu_to_memory_bus = 16'h0000;
		io_data_in = 16'h0000;
	end

	always @(posedge clk) begin
		rd_prev <= read_drive;
		if (read_drive && !rd_prev && selected) begin
			rd_word <= core[word_select];
			core[word_select] <= 16'h0000;
		end
		if (write_drive && selected)
			core[word_select] <= ~inhibit_drive;
	end

	// Outside a read the sense amps show noise, write-phase kickback included
	always @(negedge clk)
		sense_in <= (read_drive && rd_prev) ? rd_word : 16'($urandom);

	task automatic hold(input int n);
		repeat (n) @(negedge clk);
	endtask : hold

	task automatic cycle(input logic [15:0] ad, input bit io, input bit ld,
		input logic [15:0] d, output logic [15:0] rd, output logic [15:0] re);
		cpu_to_memory_bus = io ? ~ad : ad;
		io_data_in = io ? ad : 16'($urandom);
		read_io = !io;
		hold(4);
		address_latch_pulse = 1'b1;
		hold(4);
		address_latch_pulse = 1'b0;
		hold(4);
		read_io = 1'b1;
		buf_clear = 1'b1;
		hold(4);
		buf_clear = 1'b0;
		hold(4);
		read_1 = 1'b1;
		read_2 = 1'b1;
		hold(8);
		sense_strobe = 1'b1;
		hold(4);
		sense_strobe = 1'b0;
		hold(4);
		rd = mem_to_cpu_bus;
		if (ld) begin
			cpu_to_memory_bus = d;
			hold(4);
			buf_load = 1'b1;
			hold(4);
			buf_load = 1'b0;
			hold(4);
		end
		read_1 = 1'b0;
		read_2 = 1'b0;
		inhibit = 1'b1;
		hold(2);
		sense_strobe = 1'b1;
		hold(2);
		sense_strobe = 1'b0;
		hold(2);
		inhibit = 1'b0;
		hold(6);
		re = mem_to_cpu_bus;
	endtask : cycle
endmodule : cmb_cpu_model

// ===== bench/cmb_board_tb_top.sv
// Bench for the core memory board: random and corner memory cycles.
// Assumes a 1K board with a fixed code and the processor model as driver.
`timescale 1ns/10ps
module cmb_board_tb_top;
	localparam int         LW   = 10;
	localparam logic [4:0] CODE = 5'h13;
	logic          clk, rst_b, drive_io, sel_block, reload_dis, inh_tran;
	logic          address_latch_pulse, read_1, read_2, sense_strobe;
	logic          buf_load, buf_clear, inhibit, read_io;
	logic          io_data_oe, selected, read_drive, write_drive;
	logic [15:0]   sense_in, cpu_to_memory_bus, io_data_in, io_data_out;
	logic [15:0]   mem_to_cpu_bus, inhibit_drive, a;
	logic [LW-1:0] word_select;
	logic [15:0]   ref_mem [2**LW];
	logic [9:0]    pool [4] = '{10'h000, 10'h3FF, 10'h155, 10'h2AA};
	logic [4:0]    code;
	int            num_errors, samples_checked, cycles;

	cmb_board #(.BOARD_WORDS(cmb_pkg::SIZE_1K), .CODE_W(cmb_pkg::CODE_W_1K)) u_dut (
		.clk, .rst_b, .board_code(CODE), .address_latch_pulse, .read_1, .read_2,
		.sense_strobe, .buf_load, .buf_clear, .inhibit, .drive_io, .read_io,
		.sel_block, .reload_dis, .inh_tran, .sense_in, .cpu_to_memory_bus,
		.io_data_in, .io_data_out, .io_data_oe, .mem_to_cpu_bus, .selected,
		.word_select, .read_drive, .write_drive, .inhibit_drive);
	cmb_cpu_model #(.LOW_W(LW)) u_cpu (
		.clk, .read_drive, .write_drive, .selected, .word_select, .inhibit_drive,
		.mem_to_cpu_bus, .address_latch_pulse, .read_1, .read_2, .sense_strobe,
		.buf_load, .buf_clear, .inhibit, .read_io, .sense_in, .cpu_to_memory_bus,
		.io_data_in);

	always #12.5 clk = ~clk;

	always @(posedge clk) begin
		cycles++;
		if (cycles == 10000) begin
			num_errors++;
			final_report();
		end
	end

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		samples_checked++;
		if (seen !== exp) begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic do_op(input logic [15:0] ad, input bit io, input bit ld,
		input logic [15:0] d);
		logic [15:0] rd, re, old;
		logic        hit;
		hit = ad[14 -: 5] == CODE && !sel_block;
		old = ref_mem[ad[9:0]];
		u_cpu.cycle(ad, io, ld, d, rd, re);
		chk("selected", {15'h0000, selected}, {15'h0000, hit});
		chk("read word", rd, hit ? old : 16'h0000);
		if (hit && ld && !reload_dis)
			ref_mem[ad[9:0]] = d;
		chk("restored word", re, hit ? ref_mem[ad[9:0]] : 16'h0000);
		if (hit)
			chk("word select", {6'h00, word_select}, {6'h00, ad[9:0]});
	endtask : do_op

	task automatic final_report();
		if (num_errors == 0 && samples_checked > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask : final_report

	initial begin
		{clk, rst_b, drive_io, sel_block, reload_dis, inh_tran} = 6'h00;
		foreach (ref_mem[i]) ref_mem[i] = 16'h0000;
		void'($urandom(92));
		repeat (6) @(posedge clk);
		@(negedge clk);
		rst_b = 1'b1;
		for (int i = 0; i < 40; i++) begin
			code = (i % 3 == 2) ? CODE + 5'($urandom_range(1, 31)) : CODE;
			a = {1'($urandom), code, pool[$urandom_range(0, 3)]};
			do_op(a, i % 5 == 4, i % 5 != 4 && 1'($urandom), 16'($urandom));
		end
		// Blocked board must stay out of the cycle
		sel_block = 1'b1;
		do_op({1'b0, CODE, 10'h155}, 1'b0, 1'b1, 16'hA5A5);
		sel_block = 1'b0;
		reload_dis = 1'b1;
		do_op({1'b1, CODE, 10'h3FF}, 1'b0, 1'b1, 16'h5A5A);
		reload_dis = 1'b0;
		drive_io = 1'b1;
		repeat (4) @(negedge clk);
		chk("io enable", {15'h0000, io_data_oe}, 16'h0001);
		chk("io data", io_data_out, ref_mem[10'h3FF]);
		chk("memory bus", mem_to_cpu_bus, ref_mem[10'h3FF]);
		drive_io = 1'b0;
		inh_tran = 1'b1;
		repeat (4) @(negedge clk);
		chk("io enable off", {15'h0000, io_data_oe}, 16'h0000);
		chk("memory bus blocked", mem_to_cpu_bus, 16'h0000);
		inh_tran = 1'b0;
		final_report();
	end
endmodule : cmb_board_tb_top
